// ==== rtl/wfpr_pkg.sv ====
// Function
// R1: Mask word 0 of a pattern selects frame bytes 1 to 16 for the pattern CRC.
// R2: Mask word 1 of a pattern selects frame bytes 17 to 32 for the pattern CRC.
// R3: Mask word 2 of a pattern selects frame bytes 33 to 48 for the pattern CRC.
// R4: Mask word 3 selects bytes 49 to 64, and no byte past the 64th is ever used.
// R5: In each mask word bit 0 is the lowest byte of its group and bit 15 the highest.
// R6: The pattern CRC is the Ethernet 32-bit CRC taken over the masked bytes only.
// R7: The low CRC register of a pattern holds bits 15 to 0 of its expected CRC.
// R8: The high CRC register of a pattern holds bits 31 to 16 of its expected CRC.
// R9: Pattern 1 has four mask words of its own, apart from pattern 0, same grouping.
// R10: Pattern 2 has its own low CRC register, apart from those of patterns 0 and 1.
// R11: A pattern is only detected while its enable bit (bits 0 to 3) is set.
// R12: An enabled pattern is detected when the frame CRC equals its 32-bit expected value.
package wfpr_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NPAT = 2;
    localparam int NWORD = 4;
    localparam int NCRC_LO = 3;
    localparam int NEN = 4;
    localparam logic [6:0] MATCH_BYTES = 7'h40;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_CTRL = 10'h12a;
    localparam logic [9:0] IDX_MASK [NPAT][NWORD] = '{
        '{10'h134, 10'h136, 10'h138, 10'h13a},
        '{10'h144, 10'h146, 10'h148, 10'h14a}};
    localparam logic [9:0] IDX_CRC_LO [NCRC_LO] = '{10'h130, 10'h140, 10'h150};
    localparam logic [9:0] IDX_CRC_HI [NPAT] = '{10'h132, 10'h142};
    localparam logic [9:0] IDX_IRQ_STAT = 10'h170;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h172;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } wfpr_rx_beat_t;

    // Reflected form, data bits fed least significant first
    function automatic logic [31:0] wfpr_crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : wfpr_crc_byte

endpackage : wfpr_pkg

// ==== rtl/wfpr_top.sv ====
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module wfpr_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire wfpr_pkg::wfpr_rx_beat_t rx_beat,
    output logic [wfpr_pkg::NPAT-1:0] pattern_detect,
    output logic irq
);
    import wfpr_pkg::*;

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [NWORD-1:0][15:0] mask_q [NPAT];
    logic [15:0] crc_lo_q [NCRC_LO];
    logic [15:0] crc_hi_q [NPAT];
    logic [NEN-1:0] wake_pattern_control_q;
    logic [NPAT-1:0] irq_stat_q;
    logic [NPAT-1:0] irq_mask_q;
    logic [NPAT-1:0] detect_q;
    logic irq_q;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, aw_held_q, w_held_q;
    logic [1:0] bresp_q;
    logic [9:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go, wr_hit;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    assign wr_go = aw_held_q && w_held_q && !bvalid_q;

    always_comb
    begin
        wr_hit = (waddr_q == IDX_CTRL) || (waddr_q == IDX_IRQ_STAT) ||
                 (waddr_q == IDX_IRQ_MASK);
        for (int p = 0; p < NPAT; p++)
        begin
            for (int w = 0; w < NWORD; w++)
            begin
                wr_hit = wr_hit || (waddr_q == IDX_MASK[p][w]);
            end
            wr_hit = wr_hit || (waddr_q == IDX_CRC_HI[p]);
        end
        for (int p = 0; p < NCRC_LO; p++)
        begin
            wr_hit = wr_hit || (waddr_q == IDX_CRC_LO[p]);
        end
    end

    // Address and data are taken in either order; ready drops until the response is taken
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b0;
            waddr_q <= 10'h000;
        end
        else if (s_axi_awvalid && awready_q)
        begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr[11:2];
        end
        else if (bvalid_q && s_axi_bready)
        begin
            aw_held_q <= 1'b0;
        end
        else if (!aw_held_q && !bvalid_q)
        begin
            awready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wready_q <= 1'b0;
            w_held_q <= 1'b0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (s_axi_wvalid && wready_q)
        begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            w_held_q <= 1'b0;
        end
        else if (!w_held_q && !bvalid_q)
        begin
            wready_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pattern registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int p = 0; p < NPAT; p++)
            begin
                mask_q[p] <= {NWORD{REG_RESET}};
                crc_hi_q[p] <= REG_RESET;
            end
            for (int p = 0; p < NCRC_LO; p++)
            begin
                crc_lo_q[p] <= REG_RESET;
            end
        end
        else if (wr_go)
        begin
            for (int p = 0; p < NPAT; p++)
            begin
                for (int w = 0; w < NWORD; w++)
                begin
                    if (waddr_q == IDX_MASK[p][w])
                    begin
                        mask_q[p][w] <= merge16(mask_q[p][w], wdata_q, wstrb_q); // R9
                    end
                end
                if (waddr_q == IDX_CRC_HI[p])
                begin
                    crc_hi_q[p] <= merge16(crc_hi_q[p], wdata_q, wstrb_q); // R8
                end
            end
            for (int p = 0; p < NCRC_LO; p++)
            begin
                if (waddr_q == IDX_CRC_LO[p])
                begin
                    crc_lo_q[p] <= merge16(crc_lo_q[p], wdata_q, wstrb_q); // R7 R10
                end
            end
        end
    end

    // Bit 7 and the reserved bits are not kept and read back as zero
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_pattern_control_q <= 4'h0;
            irq_mask_q <= '0;
        end
        else if (wr_go && waddr_q == IDX_CTRL)
        begin
            wake_pattern_control_q <= 4'(merge16({12'h000, wake_pattern_control_q},
                                                 wdata_q, wstrb_q));
        end
        else if (wr_go && waddr_q == IDX_IRQ_MASK)
        begin
            irq_mask_q <= wstrb_q[0] ? wdata_q[NPAT-1:0] : irq_mask_q;
        end
    end

    // ----------------------------------------------------------------
    // Frame matching
    // ----------------------------------------------------------------
    logic [6:0] cnt_q;
    logic [31:0] crc_q [NPAT];
    logic [31:0] crc_nx [NPAT];
    logic in_range;

    assign in_range = cnt_q < MATCH_BYTES; // R4

    always_comb
    begin
        for (int p = 0; p < NPAT; p++)
        begin
            // Word from byte count bits 5:4, bit from 3:0, lowest byte at bit 0
            if (in_range && mask_q[p][cnt_q[5:4]][cnt_q[3:0]]) // R1 R2 R3 R4 R5
            begin
                crc_nx[p] = wfpr_crc_byte(crc_q[p], rx_beat.data); // R6
            end
            else
            begin
                crc_nx[p] = crc_q[p];
            end
        end
    end

    // Count saturates at 64 so a long frame never wraps back into the mask
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 7'h00;
            for (int p = 0; p < NPAT; p++)
            begin
                crc_q[p] <= CRC_INIT;
            end
        end
        else if (rx_beat.valid)
        begin
            cnt_q <= rx_beat.last ? 7'h00 : (in_range ? cnt_q + 7'h01 : cnt_q);
            for (int p = 0; p < NPAT; p++)
            begin
                crc_q[p] <= rx_beat.last ? CRC_INIT : crc_nx[p];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            detect_q <= '0;
        end
        else
        begin
            for (int p = 0; p < NPAT; p++)
            begin
                detect_q[p] <= rx_beat.valid && rx_beat.last && wake_pattern_control_q[p] &&
                               (~crc_nx[p] == {crc_hi_q[p], crc_lo_q[p]}); // R11 R12
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    logic [NPAT-1:0] stat_clr;

    assign stat_clr = (wr_go && waddr_q == IDX_IRQ_STAT && wstrb_q[0]) ?
                      wdata_q[NPAT-1:0] : '0;

    // A detection in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_stat_q <= (irq_stat_q & ~stat_clr) | detect_q;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    logic arready_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_hit;
    logic [15:0] rd_val;
    logic [9:0] ridx;

    assign ridx = s_axi_araddr[11:2];

    always_comb
    begin
        rd_hit = 1'b1;
        rd_val = REG_RESET;
        if (ridx == IDX_CTRL)
            rd_val = {12'h000, wake_pattern_control_q};
        else if (ridx == IDX_IRQ_STAT)
            rd_val = {14'h0000, irq_stat_q};
        else if (ridx == IDX_IRQ_MASK)
            rd_val = {14'h0000, irq_mask_q};
        else
            rd_hit = 1'b0;
        for (int p = 0; p < NPAT; p++)
        begin
            for (int w = 0; w < NWORD; w++)
            begin
                if (ridx == IDX_MASK[p][w])
                begin
                    rd_hit = 1'b1;
                    rd_val = mask_q[p][w];
                end
            end
            if (ridx == IDX_CRC_HI[p])
            begin
                rd_hit = 1'b1;
                rd_val = crc_hi_q[p];
            end
        end
        for (int p = 0; p < NCRC_LO; p++)
        begin
            if (ridx == IDX_CRC_LO[p])
            begin
                rd_hit = 1'b1;
                rd_val = crc_lo_q[p];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rd_val};
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
        else if (!rvalid_q)
        begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign pattern_detect = detect_q;
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_beat_at(int lo, int hi);
        rx_beat.valid && !rx_beat.last && cnt_q >= lo && cnt_q <= hi;
    endsequence

    sequence s_write_to(logic [9:0] idx);
        wr_go && waddr_q == idx;
    endsequence

    a_word0_unsel: assert property (@(posedge clk) disable iff (!reset_n) // R1
        s_beat_at(0, 15) and !mask_q[0][0][cnt_q[3:0]] |=> crc_q[0] == $past(crc_q[0]))
        else $error("pattern 0 CRC moved on unmasked byte of group 1");
    a_word1_sel: assert property (@(posedge clk) disable iff (!reset_n) // R2
        s_beat_at(16, 31) and mask_q[1][1][cnt_q[3:0]] |=>
        crc_q[1] == wfpr_crc_byte($past(crc_q[1]), $past(rx_beat.data)))
        else $error("pattern 1 CRC ignored masked byte of group 2");
    a_word2_unsel: assert property (@(posedge clk) disable iff (!reset_n) // R3
        s_beat_at(32, 47) and !mask_q[1][2][cnt_q[3:0]] |=> $stable(crc_q[1]))
        else $error("pattern 1 CRC moved on unmasked byte of group 3");
    a_past_64_ignored: assert property (@(posedge clk) disable iff (!reset_n) // R4
        s_beat_at(64, 127) |=> $stable(crc_q[0]) && $stable(crc_q[1]) && cnt_q == 7'h40)
        else $error("byte beyond 64 reached the CRC");
    a_bit_order: assert property (@(posedge clk) disable iff (!reset_n) // R5
        rx_beat.valid && !rx_beat.last && cnt_q == 7'h30 && mask_q[0][3][0] |=>
        crc_q[0] == wfpr_crc_byte($past(crc_q[0]), $past(rx_beat.data)))
        else $error("bit 0 of word 3 did not select byte 49");
    a_crc_step: assert property (@(posedge clk) disable iff (!reset_n) // R6
        rx_beat.valid && rx_beat.last |=> crc_q[0] == CRC_INIT && crc_q[1] == CRC_INIT)
        else $error("CRC not restarted after frame end");
    a_crc_low_write: assert property (@(posedge clk) disable iff (!reset_n) // R7
        s_write_to(IDX_CRC_LO[1]) |=> crc_lo_q[1] ==
        merge16($past(crc_lo_q[1]), $past(wdata_q), $past(wstrb_q)))
        else $error("low CRC register did not take written bits 15:0");
    a_crc_high_write: assert property (@(posedge clk) disable iff (!reset_n) // R8
        s_write_to(IDX_CRC_HI[0]) and wstrb_q == 4'hf |=> crc_hi_q[0] == $past(wdata_q[15:0]))
        else $error("high CRC register did not take written bits");
    a_mask_apart: assert property (@(posedge clk) disable iff (!reset_n) // R9
        s_write_to(IDX_MASK[1][3]) |=> $stable(mask_q[0]))
        else $error("pattern 1 mask write disturbed pattern 0");
    a_crc2_apart: assert property (@(posedge clk) disable iff (!reset_n) // R10
        s_write_to(IDX_CRC_LO[2]) |=> $stable(crc_lo_q[0]) && $stable(crc_lo_q[1]))
        else $error("pattern 2 CRC write disturbed another pattern");
    a_detect_enabled: assert property (@(posedge clk) disable iff (!reset_n) // R11
        detect_q[0] |-> $past(wake_pattern_control_q[0]) && $past(rx_beat.last))
        else $error("disabled pattern reported as detected");
    a_detect_match: assert property (@(posedge clk) disable iff (!reset_n) // R12
        detect_q[1] |=> irq_stat_q[1] ##1 (irq_q || !irq_mask_q[1]))
        else $error("detection did not reach status and interrupt");

endmodule : wfpr_top

// ==== tb/wfpr_rx_src.sv ====
`timescale 1ns/1ps
module wfpr_rx_src (
    input wire logic clk,
    output wfpr_pkg::wfpr_rx_beat_t rx_beat,
    input wire logic [wfpr_pkg::NPAT-1:0] pattern_detect
);
    import wfpr_pkg::*;

    initial rx_beat = '0;

    // ----------------------------------------------------------------
    // Frame source
    // ----------------------------------------------------------------
    // Idle data is the inverse of the last byte, so a stale byte is never reused
    task automatic send(input logic [7:0] f [80], input int len, output logic [NPAT-1:0] det);
        for (int i = 0; i < len; i++)
        begin
            rx_beat <= '{1'b1, i == len - 1, f[i]};
            @(posedge clk);
        end
        rx_beat <= '{1'b0, 1'b0, ~f[len - 1]};
        // The pulse launched by the last byte is seen at the following edge
        @(posedge clk);
        det = pattern_detect;
    endtask : send

endmodule : wfpr_rx_src

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    import wfpr_pkg::*;

    logic clk, reset_n, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    wfpr_rx_beat_t rx_beat;
    logic [NPAT-1:0] pattern_detect, det;
    int errors, tests_run;
    logic [7:0] frm [80];
    logic [15:0] msk [NPAT][NWORD];
    logic [31:0] crc [NPAT];

    wfpr_top u_wfpr_top (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_beat(rx_beat), .pattern_detect(pattern_detect), .irq(irq));

    wfpr_rx_src u_wfpr_rx_src (.clk(clk), .rx_beat(rx_beat), .pattern_detect(pattern_detect));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Address and data offered together; each released once taken
    task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= {idx, 2'b00};
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        check($sformatf("bresp %h", idx), 32'(bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [15:0] ed, input logic [1:0] er);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        check($sformatf("rdata %h", idx), rdata, {16'h0000, ed});
        check($sformatf("rresp %h", idx), 32'(rresp), 32'(er));
    endtask : rd

    // Only the first 64 bytes can ever be selected
    function automatic logic [31:0] crc_of(input logic [15:0] m [NWORD]);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int n = 0; n < 64; n++)
        begin
            if (m[n / 16][n % 16])
            begin
                for (int b = 0; b < 8; b++)
                begin
                    c = (c[0] ^ frm[n][b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
                end
            end
        end
        return ~c;
    endfunction : crc_of

    task automatic frame(input logic [1:0] exp);
        u_wfpr_rx_src.send(frm, 70, det);
        check("pattern_detect", 32'(det), 32'(exp));
    endtask : frame

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        check("irq", 32'(irq), 32'(e));
    endtask : irq_is

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        logic [9:0] rl [$];
        logic [15:0] v;
        int pos [8];
        logic [1:0] pex [8];
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        errors = 0;
        tests_run = 0;
        for (int n = 0; n < 80; n++) frm[n] = 8'(n * 37 + 11);
        msk = '{'{16'h0001, 16'h8000, 16'h0001, 16'h8000},
                '{16'h0002, 16'h0000, 16'h0000, 16'h0001}};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rl.push_back(IDX_CTRL);
        for (int i = 0; i < NCRC_LO; i++) rl.push_back(IDX_CRC_LO[i]);
        for (int p = 0; p < NPAT; p++)
        begin
            rl.push_back(IDX_CRC_HI[p]);
            for (int w = 0; w < NWORD; w++) rl.push_back(IDX_MASK[p][w]);
        end
        foreach (rl[i]) rd(rl[i], REG_RESET, RESP_OKAY);
        foreach (rl[i]) wr(rl[i], 16'hc3c3 ^ 16'(rl[i]), RESP_OKAY);
        foreach (rl[i])
        begin
            v = 16'hc3c3 ^ 16'(rl[i]);
            rd(rl[i], rl[i] == IDX_CTRL ? v & 16'h000f : v, RESP_OKAY);
        end
        rd(10'h13c, 16'h0000, RESP_SLVERR);
        wr(10'h13c, 16'hffff, RESP_SLVERR);
        // Upper byte lane only; the lower byte must keep its value
        wstrb <= 4'h2;
        wr(IDX_CRC_LO[2], 16'h5aa5, RESP_OKAY);
        wstrb <= 4'hf;
        rd(IDX_CRC_LO[2], 16'h5a93, RESP_OKAY);
        // Both patterns matched; bit 7 of the control word must not stick
        for (int p = 0; p < NPAT; p++)
        begin
            crc[p] = crc_of(msk[p]);
            for (int w = 0; w < NWORD; w++) wr(IDX_MASK[p][w], msk[p][w], RESP_OKAY);
            wr(IDX_CRC_LO[p], crc[p][15:0], RESP_OKAY);
            wr(IDX_CRC_HI[p], crc[p][31:16], RESP_OKAY);
        end
        wr(IDX_IRQ_MASK, 16'h0003, RESP_OKAY);
        wr(IDX_CTRL, 16'h0083, RESP_OKAY);
        rd(IDX_CTRL, 16'h0003, RESP_OKAY);
        frame(2'b11);
        irq_is(1'b1);
        rd(IDX_IRQ_STAT, 16'h0003, RESP_OKAY);
        wr(IDX_IRQ_STAT, 16'h0003, RESP_OKAY);
        rd(IDX_IRQ_STAT, 16'h0000, RESP_OKAY);
        irq_is(1'b0);
        // One byte spoilt at a time: only patterns selecting it must miss
        pos = '{65, 0, 1, 16, 31, 32, 63, 48};
        pex = '{2'b11, 2'b10, 2'b01, 2'b11, 2'b10, 2'b10, 2'b10, 2'b01};
        for (int i = 0; i < 8; i++)
        begin
            frm[pos[i]] ^= 8'h5a;
            frame(pex[i]);
            frm[pos[i]] ^= 8'h5a;
        end
        wr(IDX_CTRL, 16'h0001, RESP_OKAY);
        frame(2'b01);
        wr(IDX_CTRL, 16'h0000, RESP_OKAY);
        frame(2'b00);
        wr(IDX_CTRL, 16'h0003, RESP_OKAY);
        wr(IDX_CRC_HI[0], crc[0][31:16] ^ 16'h8000, RESP_OKAY);
        frame(2'b10);
        wr(IDX_CRC_HI[0], crc[0][31:16], RESP_OKAY);
        wr(IDX_CRC_LO[0], crc[0][15:0] ^ 16'h0001, RESP_OKAY);
        frame(2'b10);
        // Masked source still latches status but keeps the line low
        wr(IDX_IRQ_STAT, 16'h0003, RESP_OKAY);
        wr(IDX_IRQ_MASK, 16'h0000, RESP_OKAY);
        frame(2'b10);
        irq_is(1'b0);
        rd(IDX_IRQ_STAT, 16'h0002, RESP_OKAY);
        results();
    end

    // Whole run is well under two thousand cycles; this is far beyond it
    initial
    begin
        #100000;
        errors++;
        results();
    end

endmodule : tb
